// file: logic/usr_pkg.sv
// types shared by the synchronous serial port
`default_nettype none
package usr_pkg;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [9:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} usr_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} usr_wb_rsp_s;

	typedef struct packed {
		logic       ninth;
		logic [7:0] data;
	} usr_rx_entry_s;

	typedef enum logic [1:0] {
		USR_MODE_IDLE,
		USR_MODE_TX,
		USR_MODE_RX
	} usr_mode_e;

endpackage : usr_pkg

`default_nettype wire

// file: logic/usr_regs.svh
// register indices, field positions and reset values of the synchronous serial port
`ifndef USR_REGS_SVH
`define USR_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define USR_IDX_INT_CONTROL     8'h0b
`define USR_IDX_INT_FLAGS       8'h0c
`define USR_IDX_RX_CTRL         8'h18
`define USR_IDX_TX_BUF          8'h19
`define USR_IDX_RX_BUF          8'h1a
`define USR_IDX_INT_ENABLES     8'h8c
`define USR_IDX_TX_CTRL         8'h98
`define USR_IDX_BAUD            8'h99

// interrupt_control fields
`define USR_GLOBAL_INT_EN       7
`define USR_PERIPH_INT_EN       6
// peripheral_int_flags and peripheral_int_enables fields
`define USR_RX_FLAG             5
`define USR_TX_FLAG             4
// receive_control_status fields
`define USR_SERIAL_PORT_EN      7
`define USR_NINE_BIT_RX         6
`define USR_SINGLE_RX_EN        5
`define USR_CONT_RX_EN          4
`define USR_FRAMING_ERR         2
`define USR_OVERRUN_ERR         1
`define USR_RX_NINTH            0
// transmit_control_status fields
`define USR_CLOCK_SOURCE        7
`define USR_NINE_BIT_TX         6
`define USR_TX_EN               5
`define USR_CLOCKED_MODE        4
`define USR_HIGH_SPEED          2
`define USR_SHIFTER_EMPTY       1
`define USR_TX_NINTH            0

// reset values
`define USR_RST_INT_CONTROL     8'h00
`define USR_RST_INT_ENABLES     8'h00
`define USR_RST_TX_BUF          8'h00
`define USR_RST_BAUD            8'h00
`define USR_RST_TX_CTRL         8'h02

// word lengths in bits and receive queue depth
`define USR_BITS_SHORT          4'h8
`define USR_BITS_LONG           4'h9
`define USR_RX_DEPTH            2'h2

`endif

// file: logic/usr_sync_port.sv
// synchronous half-duplex serial port with wishbone register access
//
// What this block does
// - continuous enable, or single enable in master mode, starts synchronous reception
// - sample data on shift clock falling edge
// - single enable receives exactly one word
// - continuous enable receives until cleared
// - both enables set behaves as continuous
// - completed word enters buffer, then flag sets
// - receive interrupt gated by its enable
// - receive flag read-only, clears when emptied
// - receive buffer is two-entry ordered queue
// - full buffer at last bit sets overrun
// - overrun blocks reception; clearing continuous clears it
// - ninth bit queued with word, follows reads
// - clock source cleared selects external clock
// - slave mode keeps working during sleep; here slave edges are sampled through synchronisers clocked by clk_i
// - second word waits, transmit flag stays clear
// - second word moves, then transmit flag sets
// - transmit interrupt wakes; vector needs global enable
// - half duplex: receive and transmit exclusive
// - continuous or master single enable aborts transmit, releases data; here tsr_reg keeps its word and bit count and carries on afterwards
// - single enable self-clears, transmit resumes
// - transmit flag set on handover, cleared by write
`include "usr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module usr_sync_port (
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire usr_pkg::usr_wb_req_s wb_req_i,
	output var  usr_pkg::usr_wb_rsp_s wb_rsp_o,
	input  wire logic                 ck_i,
	output logic                      ck_o,
	output logic                      ck_oe_o,
	input  wire logic                 dt_i,
	output logic                      dt_o,
	output logic                      dt_oe_o,
	output logic                      int_request_o,
	output logic                      int_vector_o
);
	import usr_pkg::*;

	function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] code);
		reg_hit = (idx == code);
	endfunction : reg_hit

	function automatic logic [3:0] word_bits(input logic nine);
		word_bits = nine ? `USR_BITS_LONG : `USR_BITS_SHORT;
	endfunction : word_bits

	// registers
	logic [7:0]    int_ctl_reg;
	logic [7:0]    int_en_reg;
	logic [7:0]    baud_reg;
	logic [7:0]    tx_buf_reg;
	logic          tx_buf_full_reg;
	logic          tx_flag_reg;
	logic          serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, overrun_error_reg;
	logic          clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg, brgh_reg, transmit_ninth_bit_reg;
	logic          ack_reg;
	logic [31:0]   rdat_reg;
	// synchronisers
	logic          ck_s1_reg, ck_s2_reg, ck_s3_reg, dt_s1_reg, dt_s2_reg;
	// clock generator
	logic [7:0]    brg_cnt_reg;
	logic          ck_reg;
	// transmitter
	logic [8:0]    tsr_reg;
	logic          tsr_full_reg;
	logic [3:0]    tx_cnt_reg;
	logic          dt_out_reg;
	// receiver
	logic [8:0]    rsr_reg;
	logic [3:0]    rx_cnt_reg;
	usr_rx_entry_s rx_mem_reg [2];
	logic          rx_wr_ptr_reg, rx_rd_ptr_reg;
	logic [1:0]    rx_count_reg;

	// bus decode
	logic       wb_take, wb_wr, wb_rd;
	logic [7:0] idx;
	assign wb_take = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
	assign wb_wr   = wb_take & wb_req_i.we & wb_req_i.sel[0];
	assign wb_rd   = wb_take & ~wb_req_i.we;
	assign idx     = wb_req_i.adr[9:2];

	// mode
	logic      active, rx_on, shift_busy, rise, fall;
	usr_mode_e mode;
	assign active = serial_port_enable_reg & sync_reg;
	assign rx_on  = continuous_receive_enable_reg | (clock_source_select_reg & single_receive_enable_reg);

	always_comb begin
		if (!active)
			mode = USR_MODE_IDLE;
		else if (rx_on)
			mode = USR_MODE_RX;
		else if (transmit_enable_reg)
			mode = USR_MODE_TX;
		else
			mode = USR_MODE_IDLE;
	end

	// pin synchronisers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_s3_reg <= 1'b0;
			dt_s1_reg <= 1'b0;
			dt_s2_reg <= 1'b0;
		end else begin
			ck_s1_reg <= ck_i;
			ck_s2_reg <= ck_s1_reg;
			ck_s3_reg <= ck_s2_reg;
			dt_s1_reg <= dt_i;
			dt_s2_reg <= dt_s1_reg;
		end
	end

	// master shift clock: period is 2*(baud_divisor+1) clk cycles
	logic brg_run, brg_tick;
	assign brg_run  = active & clock_source_select_reg & (transmit_enable_reg | continuous_receive_enable_reg | single_receive_enable_reg);
	assign brg_tick = brg_run & (brg_cnt_reg == 8'h00);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			brg_cnt_reg <= 8'h00;
			ck_reg      <= 1'b0;
		end else if (!brg_run) begin
			brg_cnt_reg <= 8'h00;
			ck_reg      <= 1'b0;
		end else if (brg_tick) begin
			brg_cnt_reg <= baud_reg;
			if (ck_reg | shift_busy)
				ck_reg <= ~ck_reg;
		end else begin
			brg_cnt_reg <= brg_cnt_reg - 8'h01;
		end
	end

	// slave edges come from the pin through the clk_i synchronisers ck_s2_reg and ck_s3_reg, so they stop without the core clock
	always_comb begin
		if (clock_source_select_reg) begin
			rise = brg_tick & ~ck_reg & shift_busy;
			fall = brg_tick & ck_reg;
		end else begin
			rise = active & ck_s2_reg & ~ck_s3_reg;
			fall = active & ~ck_s2_reg & ck_s3_reg;
		end
	end

	// transmitter
	logic       handover;
	logic [3:0] tx_len;
	assign tx_len   = word_bits(tx9_reg);
	assign handover = active & transmit_enable_reg & ~tsr_full_reg & tx_buf_full_reg;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tsr_reg      <= 9'h000;
			tsr_full_reg <= 1'b0;
			tx_cnt_reg   <= 4'h0;
			dt_out_reg   <= 1'b0;
		end else if (!active || !transmit_enable_reg) begin
			tsr_full_reg <= 1'b0;
			tx_cnt_reg   <= 4'h0;
		end else if (handover) begin
			tsr_reg      <= {transmit_ninth_bit_reg, tx_buf_reg};
			tsr_full_reg <= 1'b1;
			tx_cnt_reg   <= 4'h0;
		end else if (mode == USR_MODE_TX && tsr_full_reg) begin
			if (rise && tx_cnt_reg < tx_len) begin
				dt_out_reg <= tsr_reg[tx_cnt_reg];
				tx_cnt_reg <= tx_cnt_reg + 4'h1;
			end else if (fall && tx_cnt_reg == tx_len) begin
				tsr_full_reg <= 1'b0;
				tx_cnt_reg   <= 4'h0;
			end
		end
	end

	// transmit buffer and its flag
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_buf_reg      <= `USR_RST_TX_BUF;
			tx_buf_full_reg <= 1'b0;
		end else if (wb_wr && reg_hit(idx, `USR_IDX_TX_BUF)) begin
			tx_buf_reg      <= wb_req_i.dat[7:0];
			tx_buf_full_reg <= 1'b1;
		end else if (handover) begin
			tx_buf_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			tx_flag_reg <= 1'b0;
		else if (handover)
			tx_flag_reg <= 1'b1;
		else if (wb_wr && reg_hit(idx, `USR_IDX_TX_BUF))
			tx_flag_reg <= 1'b0;
	end

	// receiver
	logic          rx_go, rx_last, rx_push, rx_pop;
	logic [3:0]    rx_len;
	logic [8:0]    rx_word;
	usr_rx_entry_s rx_head;
	assign rx_len  = word_bits(rx9_reg);
	assign rx_go   = (mode == USR_MODE_RX) & ~overrun_error_reg;
	assign rx_last = rx_go & fall & (rx_cnt_reg == rx_len - 4'h1);
	assign rx_push = rx_last & (rx_count_reg < `USR_RX_DEPTH);
	assign rx_pop  = wb_rd & reg_hit(idx, `USR_IDX_RX_BUF) & (rx_count_reg != 2'h0);
	assign rx_head = rx_mem_reg[rx_rd_ptr_reg];
	assign shift_busy = (mode == USR_MODE_TX) ? tsr_full_reg : rx_go;

	always_comb begin
		rx_word = rsr_reg;
		rx_word[rx_cnt_reg] = dt_s2_reg;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsr_reg    <= 9'h000;
			rx_cnt_reg <= 4'h0;
		end else if (mode != USR_MODE_RX) begin
			rx_cnt_reg <= 4'h0;
		end else if (rx_go && fall) begin
			rsr_reg <= rx_word;
			if (rx_last)
				rx_cnt_reg <= 4'h0;
			else
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
		end
	end

	// two-entry receive queue
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_mem_reg[0]  <= '0;
			rx_mem_reg[1]  <= '0;
			rx_wr_ptr_reg  <= 1'b0;
			rx_rd_ptr_reg  <= 1'b0;
			rx_count_reg   <= 2'h0;
		end else begin
			if (rx_push) begin
				rx_mem_reg[rx_wr_ptr_reg] <= '{ninth: rx9_reg & rx_word[8], data: rx_word[7:0]};
				rx_wr_ptr_reg             <= ~rx_wr_ptr_reg;
			end
			if (rx_pop)
				rx_rd_ptr_reg <= ~rx_rd_ptr_reg;
			if (rx_push && !rx_pop)
				rx_count_reg <= rx_count_reg + 2'h1;
			else if (rx_pop && !rx_push)
				rx_count_reg <= rx_count_reg - 2'h1;
		end
	end

	// receive control bits, overrun and single-word self clear
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			serial_port_enable_reg <= 1'b0;
			rx9_reg  <= 1'b0;
			single_receive_enable_reg <= 1'b0;
			continuous_receive_enable_reg <= 1'b0;
		end else begin
			if (wb_wr && reg_hit(idx, `USR_IDX_RX_CTRL)) begin
				serial_port_enable_reg <= wb_req_i.dat[`USR_SERIAL_PORT_EN];
				rx9_reg  <= wb_req_i.dat[`USR_NINE_BIT_RX];
				single_receive_enable_reg <= wb_req_i.dat[`USR_SINGLE_RX_EN];
				continuous_receive_enable_reg <= wb_req_i.dat[`USR_CONT_RX_EN];
			end
			if (rx_last && !continuous_receive_enable_reg)
				single_receive_enable_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			overrun_error_reg <= 1'b0;
		else if (rx_last && rx_count_reg == `USR_RX_DEPTH)
			overrun_error_reg <= 1'b1;
		else if (wb_wr && reg_hit(idx, `USR_IDX_RX_CTRL) && !wb_req_i.dat[`USR_CONT_RX_EN])
			overrun_error_reg <= 1'b0;
	end

	// other software registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_ctl_reg <= `USR_RST_INT_CONTROL;
			int_en_reg  <= `USR_RST_INT_ENABLES;
			baud_reg    <= `USR_RST_BAUD;
			clock_source_select_reg    <= 1'(`USR_RST_TX_CTRL >> `USR_CLOCK_SOURCE);
			tx9_reg     <= 1'b0;
			transmit_enable_reg    <= 1'b0;
			sync_reg    <= 1'b0;
			brgh_reg    <= 1'b0;
			transmit_ninth_bit_reg    <= 1'b0;
		end else if (wb_wr) begin
			if (reg_hit(idx, `USR_IDX_INT_CONTROL))
				int_ctl_reg <= wb_req_i.dat[7:0];
			if (reg_hit(idx, `USR_IDX_INT_ENABLES))
				int_en_reg <= wb_req_i.dat[7:0];
			if (reg_hit(idx, `USR_IDX_BAUD))
				baud_reg <= wb_req_i.dat[7:0];
			if (reg_hit(idx, `USR_IDX_TX_CTRL)) begin
				clock_source_select_reg <= wb_req_i.dat[`USR_CLOCK_SOURCE];
				tx9_reg  <= wb_req_i.dat[`USR_NINE_BIT_TX];
				transmit_enable_reg <= wb_req_i.dat[`USR_TX_EN];
				sync_reg <= wb_req_i.dat[`USR_CLOCKED_MODE];
				brgh_reg <= wb_req_i.dat[`USR_HIGH_SPEED];
				transmit_ninth_bit_reg <= wb_req_i.dat[`USR_TX_NINTH];
			end
		end
	end

	// read mux
	logic       rx_flag;
	logic [7:0] rd_byte;
	assign rx_flag = (rx_count_reg != 2'h0);

	always_comb begin
		rd_byte = 8'h00;
		case (idx)
			`USR_IDX_INT_CONTROL: rd_byte = int_ctl_reg;
			`USR_IDX_INT_FLAGS:   rd_byte = {2'h0, rx_flag, tx_flag_reg, 4'h0};
			`USR_IDX_RX_CTRL:     rd_byte = {serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg,
				2'h0, overrun_error_reg, rx_head.ninth};
			`USR_IDX_TX_BUF:      rd_byte = tx_buf_reg;
			`USR_IDX_RX_BUF:      rd_byte = rx_head.data;
			`USR_IDX_INT_ENABLES: rd_byte = int_en_reg;
			`USR_IDX_TX_CTRL:     rd_byte = {clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg,
				1'b0, brgh_reg, ~tsr_full_reg, transmit_ninth_bit_reg};
			`USR_IDX_BAUD:        rd_byte = baud_reg;
			default:              rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_take;
			if (wb_rd)
				rdat_reg <= {24'h00_0000, rd_byte};
		end
	end

	assign wb_rsp_o = '{ack: ack_reg, dat: rdat_reg};

	// pins
	assign ck_o    = ck_reg;
	assign ck_oe_o = brg_run;
	assign dt_o    = dt_out_reg;
	assign dt_oe_o = (mode == USR_MODE_TX);

	// interrupt request doubles as wake from sleep
	assign int_request_o = int_ctl_reg[`USR_PERIPH_INT_EN] &
		((rx_flag & int_en_reg[`USR_RX_FLAG]) | (tx_flag_reg & int_en_reg[`USR_TX_FLAG]));
	assign int_vector_o  = int_request_o & int_ctl_reg[`USR_GLOBAL_INT_EN];

endmodule : usr_sync_port

`default_nettype wire

// file: test/test_usr_sync_port.sv
// self-checking bench of the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
module test_usr_sync_port;
	import usr_pkg::*;
	logic        clk_i, reset_n_i, ck_o, ck_oe_o, dt_o, dt_oe_o, irq, vec, peer_ck, peer_dt;
	usr_wb_req_s req;
	usr_wb_rsp_s rsp;
	int          bad_count = 0;
	int          n_checks = 0;
	wire ck_line = ck_oe_o ? ck_o : peer_ck;
	wire dt_line = dt_oe_o ? dt_o : peer_dt;
	usr_sync_port dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_req_i(req), .wb_rsp_o(rsp), .ck_i(ck_line),
		.ck_o(ck_o), .ck_oe_o(ck_oe_o), .dt_i(dt_line), .dt_o(dt_o), .dt_oe_o(dt_oe_o), .int_request_o(irq),
		.int_vector_o(vec));
	usr_peer peer (.ck_line_i(ck_line), .dt_line_i(dt_line), .ck_drv_o(peer_ck), .dt_drv_o(peer_dt));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	// one classic cycle; entered just after a rising edge
	task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h000000, wd}};
		@(posedge clk_i);
		while (rsp.ack !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = rsp.dat[7:0];
		req <= '0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] v;
		bus(1'b1, idx, d, v);
	endtask : wr
	task automatic rc(input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] v;
		bus(1'b0, idx, 8'h00, v);
		chk({1'b0, v}, {1'b0, e}, "register");
	endtask : rc
	task automatic poll(input logic [7:0] idx, input int b);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 200 && v[b] !== 1'b1; i++) bus(1'b0, idx, 8'h00, v);
		chk(9'(v[b]), 9'h001, "status bit");
	endtask : poll
	task automatic t_reset_values();
		logic [7:0] idx [9] = '{8'h0b, 8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h50};
		logic [7:0] exp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
		foreach (idx[i]) rc(idx[i], exp[i]);
		wr(8'h0c, 8'hff);
		wr(8'h99, 8'h3c);
		wr(8'h50, 8'h77);
		rc(8'h0c, 8'h00);
		rc(8'h99, 8'h3c);
		rc(8'h50, 8'h00);
	endtask : t_reset_values
	task automatic t_master_single();
		wr(8'h99, 8'h07);
		wr(8'h98, 8'hb0);
		wr(8'h18, 8'h80);
		chk(9'(dt_oe_o), 9'h001, "data drive");
		peer.q = 27'h00001a5;
		peer.resp_en = 1'b1;
		wr(8'h18, 8'he0);
		chk(9'(dt_oe_o), 9'h000, "data drive");
		poll(8'h0c, 5);
		peer.release_dt();
		repeat (200) @(posedge clk_i);
		rc(8'h18, 8'hc1);
		chk(9'(dt_oe_o), 9'h001, "data drive");
		rc(8'h1a, 8'ha5);
		rc(8'h0c, 8'h00);
	endtask : t_master_single
	task automatic t_continuous_overrun();
		wr(8'h98, 8'h90);
		wr(8'h18, 8'h80);
		peer.q = 27'h0332211;
		peer.resp_en = 1'b1;
		wr(8'h18, 8'hb0);
		poll(8'h18, 1);
		peer.release_dt();
		rc(8'h18, 8'hb2);
		rc(8'h0c, 8'h20);
		rc(8'h1a, 8'h11);
		rc(8'h0c, 8'h20);
		rc(8'h1a, 8'h22);
		rc(8'h0c, 8'h00);
		wr(8'h18, 8'h80);
		rc(8'h18, 8'h80);
	endtask : t_continuous_overrun
	task automatic t_slave_transmit();
		wr(8'h18, 8'h80);
		wr(8'h98, 8'h30);
		wr(8'h8c, 8'h10);
		wr(8'h0b, 8'h40);
		wr(8'h19, 8'h5a);
		wr(8'h19, 8'hc3);
		rc(8'h0c, 8'h00);
		chk(9'(irq), 9'h000, "request");
		peer.frame(8);
		repeat (10) @(posedge clk_i);
		chk(peer.cap, 9'h05a, "first word");
		rc(8'h0c, 8'h10);
		chk(9'(irq), 9'h001, "request");
		chk(9'(vec), 9'h000, "vector");
		wr(8'h0b, 8'hc0);
		chk(9'(vec), 9'h001, "vector");
		wr(8'h8c, 8'h00);
		chk(9'(irq), 9'h000, "request");
		peer.frame(8);
		chk(peer.cap, 9'h0c3, "second word");
	endtask : t_slave_transmit
	task automatic t_slave_receive();
		wr(8'h98, 8'h10);
		wr(8'h18, 8'hd0);
		wr(8'h8c, 8'h20);
		peer.q = 27'h00001c3;
		peer.resp_en = 1'b1;
		peer.frame(9);
		peer.release_dt();
		repeat (10) @(posedge clk_i);
		chk(9'(irq), 9'h001, "request");
		wr(8'h0b, 8'h80);
		chk(9'(irq), 9'h000, "request");
		wr(8'h0b, 8'hc0);
		rc(8'h18, 8'hd1);
		rc(8'h1a, 8'hc3);
		chk(9'(irq), 9'h000, "request");
		wr(8'h18, 8'h80);
	endtask : t_slave_receive
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		close_out();
	end
	initial begin
		reset_n_i = 1'b0;
		req = '0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset_values();
		t_master_single();
		t_continuous_overrun();
		t_slave_transmit();
		t_slave_receive();
		close_out();
	end
endmodule : test_usr_sync_port
`default_nettype wire

// file: test/usr_peer.sv
// far-side serial peer: shift clock source in slave mode, data source and sink
`timescale 1ns/1ps
`default_nettype none
module usr_peer (
	input  wire logic ck_line_i,
	input  wire logic dt_line_i,
	output logic      ck_drv_o,
	output logic      dt_drv_o
);
	logic        resp_en;
	logic [26:0] q;
	logic [8:0]  cap;
	initial begin
		ck_drv_o = 1'b0;
		dt_drv_o = 1'b1;
		resp_en = 1'b0;
		q = '0;
		cap = '0;
	end
	// next bit, lsb first, after each rising shift edge
	always @(posedge ck_line_i) begin
		if (resp_en) begin
			dt_drv_o <= q[0];
			q <= q >> 1;
		end
	end
	// released line shows the inverse of its last level
	task automatic release_dt();
		resp_en = 1'b0;
		dt_drv_o = ~dt_drv_o;
	endtask : release_dt
	// one frame at the 400 ns link clock, which stands low outside it
	task automatic frame(input int n);
		cap = '0;
		repeat (n) begin
			ck_drv_o = 1'b1;
			#200;
			ck_drv_o = 1'b0;
			#190;
			cap = {dt_line_i, cap[8:1]};
			#10;
		end
		cap = cap >> (9 - n);
	endtask : frame
endmodule : usr_peer
`default_nettype wire

// file: test/usr_sync_port_assertions.sv
// concurrent checks on the serial port's bus, data-drive and interrupt outputs
`timescale 1ns/1ps
`default_nettype none
module usr_sync_port_chk (
	input wire logic                 clk_i,
	input wire logic                 reset_n_i,
	input wire usr_pkg::usr_wb_req_s wb_req_i,
	input wire usr_pkg::usr_wb_rsp_s wb_rsp_o,
	input wire logic                 ck_i,
	input wire logic                 ck_o,
	input wire logic                 ck_oe_o,
	input wire logic                 dt_i,
	input wire logic                 dt_o,
	input wire logic                 dt_oe_o,
	input wire logic                 int_request_o,
	input wire logic                 int_vector_o
);
	import usr_pkg::*;
	logic take;
	logic wr0;
	assign take = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
	assign wr0 = take & wb_req_i.we & wb_req_i.sel[0];
	// global enable as last written over the bus
	logic gie_seen;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			gie_seen <= 1'b0;
		else if (wr0 && wb_req_i.adr[9:2] == 8'h0b)
			gie_seen <= wb_req_i.dat[7];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_ack_after_take: assert property (take |=> wb_rsp_o.ack)
		else $error("no ack after request");
	a_ack_single_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack held too long");
	a_ack_needs_request: assert property (wb_rsp_o.ack |-> $past(take))
		else $error("ack without request");
	a_read_upper_zero: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_flags_spare_zero: assert property (take & !wb_req_i.we & (wb_req_i.adr[9:2] == 8'h0c) |=>
		wb_rsp_o.dat[7:6] == 2'h0 && wb_rsp_o.dat[3:0] == 4'h0) else $error("spare flag bits set");
	a_abort_releases_data: assert property (wr0 & (wb_req_i.adr[9:2] == 8'h18) &
		(wb_req_i.dat[4] | wb_req_i.dat[5] & ck_oe_o) |=> !dt_oe_o) else $error("data still driven");
	a_vector_needs_request: assert property (int_vector_o == (int_request_o && gie_seen))
		else $error("vector without request");
	a_vector_gate_off: assert property (wr0 & (wb_req_i.adr[9:2] == 8'h0b) & !wb_req_i.dat[7] |=> !int_vector_o)
		else $error("vector with global enable clear");
	a_request_gate_off: assert property (wr0 & (wb_req_i.adr[9:2] == 8'h0b) & !wb_req_i.dat[6] |=> !int_request_o)
		else $error("request with peripheral enable clear");
endmodule : usr_sync_port_chk
bind usr_sync_port usr_sync_port_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_req_i(wb_req_i),
	.wb_rsp_o(wb_rsp_o), .ck_i(ck_i), .ck_o(ck_o), .ck_oe_o(ck_oe_o), .dt_i(dt_i), .dt_o(dt_o),
	.dt_oe_o(dt_oe_o), .int_request_o(int_request_o), .int_vector_o(int_vector_o));
`default_nettype wire
